// file: ext_prog_mem.sv
// Behavioural external program memory answering routed fetches.
`timescale 1ns/100ps
module ext_prog_mem (
  input  wire logic                 i_ref_clk,
  input  wire pc_stack_pkg::fetch_s i_fetch,
  output logic [15:0]               o_word,
  output logic [15:0]               o_hits
);
  initial o_word = 16'h0000;
  initial o_hits = 16'h0000;
  // Deselected, the bus inverts every cycle, so stale data matches again on every second cycle.
  always @(posedge i_ref_clk)
  begin
    if (i_fetch.use_external && !i_fetch.blocked)
    begin
      o_word <= i_fetch.addr[15:0] ^ 16'hA5A5;
      o_hits <= o_hits + 16'h0001;
    end
    else
      o_word <= ~o_word;
  end
endmodule

// file: pc_stack_chk.sv
// Concurrent checks on the ports of the program counter and return stack unit.
`timescale 1ns/100ps
module pc_stack_chk (
  input wire logic                    i_ref_clk,
  input wire logic                    i_reset,
  input wire pc_stack_pkg::flow_req_s i_flow,
  input wire logic [3:0]              i_addr,
  input wire logic [7:0]              i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [7:0]              o_rdata,
  input wire pc_stack_pkg::fetch_s    o_fetch,
  input wire logic                    o_stack_reset
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic pcl_wr;
  logic jmp;
  assign pcl_wr = i_wr && i_addr == pc_stack_pkg::ADDR_COUNTER_LOW;
  assign jmp = i_flow.op == pc_stack_pkg::FLOW_JUMP || i_flow.op == pc_stack_pkg::FLOW_CALL;
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  a_fetch_even: assert property (o_fetch.addr[0] == 1'b0)
    else $error("fetch address odd");
  // A stack reset pulse in flight may legally override the flow request.
  a_step_two: assert property (i_flow.op == pc_stack_pkg::FLOW_STEP
    && !pcl_wr && !o_stack_reset
    |=> ##1 o_fetch.addr == $past(o_fetch.addr) + pc_stack_pkg::PC_STEP)
    else $error("step did not add two");
  a_jump_target: assert property (jmp && !pcl_wr && !o_stack_reset
    |=> ##1 o_fetch.addr == ($past(i_flow.target, 2) & ~21'h1))
    else $error("jump target not loaded");
  a_pcl_load: assert property (pcl_wr && !o_stack_reset
    |=> ##1 o_fetch.addr[7:0] == ($past(i_wdata, 2) & 8'hFE))
    else $error("low byte write not loaded");
  a_sreset_pulse: assert property (o_stack_reset |=> !o_stack_reset)
    else $error("stack reset longer than one cycle");
  a_sreset_cause: assert property (o_stack_reset
    |-> $past(i_flow.op) == pc_stack_pkg::FLOW_CALL)
    else $error("stack reset without push");
  a_sreset_clears: assert property (o_stack_reset |=> ##1 o_fetch.addr == 21'h0)
    else $error("stack reset left counter");
  a_ptr_bit5: assert property (i_rd && i_addr == pc_stack_pkg::ADDR_STACK_POINTER
    |=> o_rdata[5] == 1'b0)
    else $error("pointer bit five set");
  c_call: cover property (i_flow.op == pc_stack_pkg::FLOW_CALL);
  c_sreset: cover property (o_stack_reset);
  c_pcl: cover property (pcl_wr);
endmodule
bind program_counter_return_stack pc_stack_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_flow(i_flow), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_fetch(o_fetch), .o_stack_reset(o_stack_reset));

// file: pc_stack_pkg.sv
// Package with constants and types for the program counter and return stack unit.
package pc_stack_pkg;

  localparam int unsigned PC_W        = 21;
  localparam int unsigned SP_W        = 5;
  localparam int unsigned STACK_DEPTH = 31;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_COUNTER_LOW    = 4'h0;
  localparam logic [3:0] ADDR_HIGH_LATCH     = 4'h1;
  localparam logic [3:0] ADDR_UPPER_LATCH    = 4'h2;
  localparam logic [3:0] ADDR_STACK_POINTER  = 4'h3;
  localparam logic [3:0] ADDR_STACK_TOP_LOW  = 4'h4;
  localparam logic [3:0] ADDR_STACK_TOP_HIGH = 4'h5;
  localparam logic [3:0] ADDR_STACK_TOP_UPR  = 4'h6;
  localparam logic [3:0] ADDR_MEMORY_CONFIG  = 4'h7;
  localparam logic [3:0] ADDR_STACK_CONFIG   = 4'h8;

  // Field positions.
  localparam int unsigned FULL_BIT      = 7;
  localparam int unsigned UNDERFLOW_BIT = 6;
  localparam int unsigned ORE_BIT       = 0;

  // Reset values and counter step.
  localparam logic [7:0] MEMORY_CONFIG_RST = 8'h03;
  localparam logic [7:0] STACK_CONFIG_RST  = 8'h01;
  localparam logic [PC_W-1:0] PC_RST       = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP      = 21'h000002;

  // Region limits.
  localparam logic [PC_W-1:0] FLASH_TOP_SMALL = 21'h017FFF;
  localparam logic [PC_W-1:0] FLASH_TOP_LARGE = 21'h01FFFF;
  localparam logic [PC_W-1:0] BOOT_TOP_1K     = 21'h0003FF;
  localparam logic [PC_W-1:0] BOOT_TOP_2K     = 21'h0007FF;
  localparam logic [PC_W-1:0] BOOT_TOP_4K     = 21'h000FFF;

  typedef enum logic [1:0] {
    EXTERNAL_ONLY_MEMORY_MODE = 2'b00,
    BOOT_PLUS_EXTERNAL_MODE   = 2'b01,
    MIXED_MEMORY_MODE         = 2'b10,
    INTERNAL_ONLY_MEMORY_MODE = 2'b11
  } mem_mode_e;

  typedef enum logic [2:0] {
    FLOW_NONE   = 3'b000,
    FLOW_STEP   = 3'b001,
    FLOW_JUMP   = 3'b010,
    FLOW_CALL   = 3'b011,
    FLOW_RETURN = 3'b100
  } flow_op_e;

  // One program-flow request per cycle from the instruction sequencer.
  typedef struct packed {
    flow_op_e        op;
    logic [PC_W-1:0] target;
  } flow_req_s;

  // Fetch routing: which memory serves the address, and whether it is blocked.
  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic            use_external;
    logic            blocked;
    logic            zero_fill;
  } fetch_s;

  typedef struct packed {
    logic            valid;
    logic [PC_W-1:0] addr;
  } table_req_s;

endpackage

// file: program_counter_return_stack.sv
// Program counter, latch registers, return stack and program memory mode decoding.
`timescale 1ns/100ps

// Functional notes
// R1 - Memory mode comes from the two low bits of the memory config byte.
// R2 - External-only mode fetches everything from external memory over 2 MByte.
// R3 - Boot-plus-external uses flash in 1, 2 or 4 KB boot area, external above.
// R4 - Internal-only mode uses flash; reads above flash top return zeros.
// R5 - Mixed mode puts all flash first, external memory above it.
// R6 - Blocked regions refuse execution, table reads and table writes.
// R7 - Program counter is 21 bits; only its low byte is software accessible.
// R8 - Writing the low byte loads counter bits 20:8 from the latches.
// R9 - Reading the low byte copies counter bits 20:8 into the latches.
// R10 - Counter bit 0 stays zero; sequential step adds two.
// R11 - Calls, jumps and branches load the counter without using the latches.
// R12 - Calls and interrupts push, returns pop, latches untouched, 31 levels.
// R13 - Return stack is 31 entries of 21 bits indexed by a 5-bit pointer.
// R14 - Push increments the pointer first, then writes the return address.
// R15 - Pop loads the counter from the selected entry, then decrements.
// R16 - Pointer resets to zero; zero has no storage and means empty.
// R17 - Top-of-stack bytes and pointer are readable and writable by software.
// R18 - Software disables interrupts while it touches the stack registers.
// R19 - Thirty-one pushes set the full flag; only software or power-on clears it.
// R20 - With overflow reset enabled, the 31st push stores, flags and resets the device.
// R21 - With it disabled, pointer stops at 31 and further pushes are dropped.
// R22 - Pop when empty loads zero, sets underflow flag, pointer stays zero.
// R23 - Pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer 4:0.
module program_counter_return_stack #(
  parameter bit LARGE_FLASH = 1'b1
) (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_reset,
  input  wire logic                           i_power_on_reset,
  input  wire pc_stack_pkg::flow_req_s        i_flow,
  input  wire pc_stack_pkg::table_req_s       i_table,
  input  wire logic [3:0]                     i_addr,
  input  wire logic [7:0]                     i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic [7:0]                          o_rdata,
  output pc_stack_pkg::fetch_s                o_fetch,
  output logic                                o_table_external,
  output logic                                o_table_blocked,
  output logic                                o_stack_reset
);

  localparam int unsigned W = pc_stack_pkg::PC_W;
  localparam logic [4:0] SP_MAX = 5'(pc_stack_pkg::STACK_DEPTH);

  logic [W-1:0] pc_r;
  logic [7:0]   high_latch_r;
  logic [4:0]   upper_latch_r;
  logic [4:0]   sp_r;
  logic         full_r;
  logic         underflow_r;
  logic [7:0]   mem_cfg_r;
  logic [7:0]   stk_cfg_r;
  logic [W-1:0] stack_r [1:pc_stack_pkg::STACK_DEPTH];
  logic         stack_reset_r;

  pc_stack_pkg::mem_mode_e mode;
  logic [W-1:0] flash_top;
  logic [W-1:0] boot_top;
  logic         ore;
  logic         is_push;
  logic         is_pop;
  logic         push_ok;
  logic         push_overflow_reset;
  logic [W-1:0] ret_addr;
  logic         wr_low;
  logic         rd_low;
  logic [W-1:0] top_entry;

  assign mode = pc_stack_pkg::mem_mode_e'(mem_cfg_r[1:0]); // [R1]
  assign flash_top = LARGE_FLASH ? pc_stack_pkg::FLASH_TOP_LARGE
                                 : pc_stack_pkg::FLASH_TOP_SMALL;
  assign ore = stk_cfg_r[pc_stack_pkg::ORE_BIT];
  assign is_push = (i_flow.op == pc_stack_pkg::FLOW_CALL);
  assign is_pop = (i_flow.op == pc_stack_pkg::FLOW_RETURN);
  // Once the pointer sits at 31 further pushes are simply dropped.
  assign push_ok = is_push && (sp_r != SP_MAX); // [R21]
  assign push_overflow_reset = push_ok && (sp_r == SP_MAX - 5'h01) && ore; // [R20]
  assign ret_addr = pc_r + pc_stack_pkg::PC_STEP; // [R14]
  assign wr_low = i_wr && (i_addr == pc_stack_pkg::ADDR_COUNTER_LOW);
  assign rd_low = i_rd && (i_addr == pc_stack_pkg::ADDR_COUNTER_LOW);
  // Pointer zero has no storage behind it and reads as zero.
  assign top_entry = (sp_r == 5'h00) ? '0 : stack_r[sp_r]; // [R16]

  always_comb
  begin
    unique case (stk_cfg_r[2:1])
      2'b00:   boot_top = pc_stack_pkg::BOOT_TOP_1K;
      2'b01:   boot_top = pc_stack_pkg::BOOT_TOP_2K;
      default: boot_top = pc_stack_pkg::BOOT_TOP_4K;
    endcase
  end

  // Configuration bytes; a device reset does not alter them.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_power_on_reset)
    begin
      mem_cfg_r <= pc_stack_pkg::MEMORY_CONFIG_RST;
      stk_cfg_r <= pc_stack_pkg::STACK_CONFIG_RST;
    end
    else if (i_wr && i_addr == pc_stack_pkg::ADDR_MEMORY_CONFIG)
      mem_cfg_r <= i_wdata;
    else if (i_wr && i_addr == pc_stack_pkg::ADDR_STACK_CONFIG)
      stk_cfg_r <= i_wdata;
  end

  // Program counter; bit 0 is forced to zero on every load.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || stack_reset_r)
      pc_r <= pc_stack_pkg::PC_RST;
    else if (wr_low)
      pc_r <= {upper_latch_r, high_latch_r, i_wdata[7:1], 1'b0}; // [R7] [R8] [R10]
    else
    begin
      unique case (i_flow.op)
        pc_stack_pkg::FLOW_STEP:
          pc_r <= pc_r + pc_stack_pkg::PC_STEP; // [R10]
        pc_stack_pkg::FLOW_JUMP,
        pc_stack_pkg::FLOW_CALL:
          pc_r <= {i_flow.target[W-1:1], 1'b0}; // [R11]
        pc_stack_pkg::FLOW_RETURN:
          pc_r <= {top_entry[W-1:1], 1'b0}; // [R15] [R22]
        default:
          pc_r <= pc_r;
      endcase
    end
  end

  // Latches are loaded by software or by a low-byte read, never by calls or returns.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      high_latch_r  <= 8'h00;
      upper_latch_r <= 5'h00;
    end
    else if (rd_low)
    begin
      high_latch_r  <= pc_r[15:8]; // [R9]
      upper_latch_r <= pc_r[20:16]; // [R9]
    end
    else if (i_wr && i_addr == pc_stack_pkg::ADDR_HIGH_LATCH)
      high_latch_r <= i_wdata;
    else if (i_wr && i_addr == pc_stack_pkg::ADDR_UPPER_LATCH)
      upper_latch_r <= i_wdata[4:0]; // [R12]
  end

  // Stack pointer. Software writes lose against an accepted push or a pop from a non-empty stack in the same cycle.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || stack_reset_r)
      sp_r <= 5'h00; // [R16] [R20]
    else if (push_ok)
      sp_r <= sp_r + 5'h01; // [R14] [R12]
    else if (is_pop && sp_r != 5'h00)
      sp_r <= sp_r - 5'h01; // [R15]
    else if (i_wr && i_addr == pc_stack_pkg::ADDR_STACK_POINTER)
      sp_r <= i_wdata[4:0]; // [R17]
  end

  // Status flags: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_power_on_reset)
    begin
      full_r      <= 1'b0;
      underflow_r <= 1'b0;
    end
    else
    begin
      if (push_ok && sp_r == SP_MAX - 5'h01)
        full_r <= 1'b1; // [R19] [R20] [R21]
      else if (i_wr && i_addr == pc_stack_pkg::ADDR_STACK_POINTER)
        full_r <= full_r & i_wdata[pc_stack_pkg::FULL_BIT]; // [R19]
      if (is_pop && sp_r == 5'h00)
        underflow_r <= 1'b1; // [R22]
      else if (i_wr && i_addr == pc_stack_pkg::ADDR_STACK_POINTER)
        underflow_r <= underflow_r & i_wdata[pc_stack_pkg::UNDERFLOW_BIT]; // [R22]
    end
  end

  // Stack storage. Entries survive resets; only the pointer is cleared.
  always_ff @(posedge i_ref_clk)
  begin
    if (push_ok && !i_reset)
      stack_r[sp_r + 5'h01] <= ret_addr; // [R13] [R14] [R20]
    else if (i_wr && sp_r != 5'h00)
    begin
      unique case (i_addr)
        pc_stack_pkg::ADDR_STACK_TOP_LOW:
          stack_r[sp_r][7:0] <= i_wdata; // [R17]
        pc_stack_pkg::ADDR_STACK_TOP_HIGH:
          stack_r[sp_r][15:8] <= i_wdata; // [R17]
        pc_stack_pkg::ADDR_STACK_TOP_UPR:
          stack_r[sp_r][20:16] <= i_wdata[4:0]; // [R17]
        default:
          stack_r[sp_r] <= stack_r[sp_r];
      endcase
    end
  end

  // A full stack with overflow reset enabled requests a one-cycle device reset.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      stack_reset_r <= 1'b0;
    else
      stack_reset_r <= push_overflow_reset; // [R20]
  end

  assign o_stack_reset = stack_reset_r;

  // Fetch routing for the counter value.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      o_fetch <= '0;
    else
    begin
      o_fetch.addr <= pc_r;
      unique case (mode)
        pc_stack_pkg::EXTERNAL_ONLY_MEMORY_MODE:
        begin
          o_fetch.use_external <= 1'b1; // [R2]
          o_fetch.blocked      <= 1'b0;
          o_fetch.zero_fill    <= 1'b0;
        end
        pc_stack_pkg::BOOT_PLUS_EXTERNAL_MODE:
        begin
          o_fetch.use_external <= (pc_r > boot_top); // [R3]
          o_fetch.blocked      <= 1'b0;
          o_fetch.zero_fill    <= 1'b0;
        end
        pc_stack_pkg::MIXED_MEMORY_MODE:
        begin
          o_fetch.use_external <= (pc_r > flash_top); // [R5]
          o_fetch.blocked      <= 1'b0;
          o_fetch.zero_fill    <= 1'b0;
        end
        pc_stack_pkg::INTERNAL_ONLY_MEMORY_MODE:
        begin
          o_fetch.use_external <= 1'b0; // [R6]
          o_fetch.blocked      <= (pc_r > flash_top); // [R6]
          o_fetch.zero_fill    <= (pc_r > flash_top); // [R4]
        end
      endcase
    end
  end

  // Table access routing follows the same map as execution.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_table_external <= 1'b0;
      o_table_blocked  <= 1'b0;
    end
    else
    begin
      unique case (mode)
        pc_stack_pkg::EXTERNAL_ONLY_MEMORY_MODE:
        begin
          o_table_external <= 1'b1;
          o_table_blocked  <= 1'b0;
        end
        pc_stack_pkg::BOOT_PLUS_EXTERNAL_MODE:
        begin
          o_table_external <= i_table.valid && (i_table.addr > boot_top);
          o_table_blocked  <= 1'b0;
        end
        pc_stack_pkg::MIXED_MEMORY_MODE:
        begin
          o_table_external <= i_table.valid && (i_table.addr > flash_top);
          o_table_blocked  <= 1'b0;
        end
        pc_stack_pkg::INTERNAL_ONLY_MEMORY_MODE:
        begin
          o_table_external <= 1'b0;
          o_table_blocked  <= i_table.valid && (i_table.addr > flash_top); // [R6]
        end
      endcase
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || !i_rd)
      o_rdata <= 8'h00;
    else
    begin
      unique case (i_addr)
        pc_stack_pkg::ADDR_COUNTER_LOW:    o_rdata <= pc_r[7:0]; // [R7]
        pc_stack_pkg::ADDR_HIGH_LATCH:     o_rdata <= high_latch_r;
        pc_stack_pkg::ADDR_UPPER_LATCH:    o_rdata <= {3'h0, upper_latch_r};
        pc_stack_pkg::ADDR_STACK_POINTER:  o_rdata <= {full_r, underflow_r, 1'b0, sp_r}; // [R23]
        pc_stack_pkg::ADDR_STACK_TOP_LOW:  o_rdata <= top_entry[7:0]; // [R17]
        pc_stack_pkg::ADDR_STACK_TOP_HIGH: o_rdata <= top_entry[15:8]; // [R17]
        pc_stack_pkg::ADDR_STACK_TOP_UPR:  o_rdata <= {3'h0, top_entry[20:16]}; // [R17]
        pc_stack_pkg::ADDR_MEMORY_CONFIG:  o_rdata <= mem_cfg_r;
        pc_stack_pkg::ADDR_STACK_CONFIG:   o_rdata <= stk_cfg_r;
        default:                           o_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// file: tb_program_counter_return_stack.sv
// Self-checking bench for the program counter and return stack unit.
`timescale 1ns/100ps
module tb_program_counter_return_stack;
  logic                     i_ref_clk, i_reset, i_power_on_reset, i_wr, i_rd;
  pc_stack_pkg::flow_req_s  i_flow;
  pc_stack_pkg::table_req_s i_table;
  pc_stack_pkg::fetch_s     o_fetch;
  logic [3:0]               i_addr;
  logic [7:0]               i_wdata, o_rdata;
  logic                     o_table_external, o_table_blocked, o_stack_reset, full, unf;
  logic [15:0]              ext_word, ext_hits, lf, h0;
  logic [20:0]              pc, t, stk [32];
  logic [20:0]              addrs [6] = '{21'h3FE, 21'h400, 21'hFFE,
                                          21'h1FFFE, 21'h20000, 21'h1FFFFE};
  logic [4:0]               sp;
  logic [1:0]               rt;
  int                       n_fail, check_count, n_sres;
  program_counter_return_stack dut (.i_ref_clk, .i_reset, .i_power_on_reset, .i_flow, .i_table,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_fetch, .o_table_external, .o_table_blocked,
    .o_stack_reset);
  ext_prog_mem mem (.i_ref_clk, .i_fetch(o_fetch), .o_word(ext_word), .o_hits(ext_hits));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
    if (o_stack_reset === 1'b1)
      n_sres++;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Returns {fetch goes external, fetch reads zeros}.
  function automatic logic [1:0] route(input int m, input int b, input logic [20:0] a);
    logic [20:0] top;
    top = (b == 0) ? 21'h3FF : (b == 1) ? 21'h7FF : 21'hFFF;
    case (m)
      0: return 2'b10;
      1: return {a > top, 1'b0};
      2: return {a > 21'h1FFFF, 1'b0};
      default: return {1'b0, a > 21'h1FFFF};
    endcase
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  task automatic see();
    @(posedge i_ref_clk);
    #1;
    chk(o_fetch.addr, pc);
  endtask
  task automatic op(input pc_stack_pkg::flow_op_e o, input logic [20:0] a);
    @(posedge i_ref_clk);
    i_flow <= {o, a};
    @(posedge i_ref_clk);
    i_flow <= {pc_stack_pkg::FLOW_NONE, 21'h0};
    case (o)
      pc_stack_pkg::FLOW_STEP: pc = pc + 21'h2;
      pc_stack_pkg::FLOW_JUMP: pc = a & ~21'h1;
      pc_stack_pkg::FLOW_CALL:
      begin
        if (sp != 5'd31)
        begin
          sp++;
          stk[sp] = pc + 21'h2;
        end
        full |= sp == 5'd31;
        pc = a & ~21'h1;
      end
      default:
      begin
        unf |= sp == 5'd0;
        pc = (sp == 5'd0) ? 21'h0 : stk[sp];
        if (sp != 5'd0)
          sp--;
      end
    endcase
    see();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (10000) @(posedge i_ref_clk);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    {i_reset, i_power_on_reset, i_wr, i_rd, i_addr, i_wdata} = {2'b11, 14'h0};
    {i_flow, i_table} = '0;
    {n_fail, check_count, n_sres, lf, pc, sp, full, unf} = {96'h0, 16'hE518, 28'h0};
    repeat (2) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    i_power_on_reset <= 1'b0;
    rd(pc_stack_pkg::ADDR_STACK_POINTER, 8'h00);
    rd(pc_stack_pkg::ADDR_MEMORY_CONFIG, 8'h03);
    rd(pc_stack_pkg::ADDR_STACK_CONFIG, 8'h01);
    rd(4'hF, 8'h00);
    wr(pc_stack_pkg::ADDR_HIGH_LATCH, 8'h34);
    wr(pc_stack_pkg::ADDR_UPPER_LATCH, 8'h15);
    wr(pc_stack_pkg::ADDR_COUNTER_LOW, 8'h57);
    pc = 21'h153456;
    see();
    op(pc_stack_pkg::FLOW_JUMP, 21'h0ABCDE);
    rd(pc_stack_pkg::ADDR_COUNTER_LOW, 8'hDE);
    rd(pc_stack_pkg::ADDR_HIGH_LATCH, 8'hBC);
    rd(pc_stack_pkg::ADDR_UPPER_LATCH, 8'h0A);
    op(pc_stack_pkg::FLOW_CALL, 21'h001000);
    rd(pc_stack_pkg::ADDR_STACK_TOP_LOW, stk[1][7:0]);
    rd(pc_stack_pkg::ADDR_STACK_TOP_HIGH, stk[1][15:8]);
    rd(pc_stack_pkg::ADDR_STACK_TOP_UPR, {3'b000, stk[1][20:16]});
    wr(pc_stack_pkg::ADDR_STACK_TOP_LOW, 8'h40);
    stk[1][7:0] = 8'h40;
    // A high byte unlike the latch shows that the return leaves the latches alone.
    wr(pc_stack_pkg::ADDR_STACK_TOP_HIGH, 8'h77);
    stk[1][15:8] = 8'h77;
    op(pc_stack_pkg::FLOW_RETURN, 21'h0);
    rd(pc_stack_pkg::ADDR_HIGH_LATCH, 8'hBC);
    wr(4'hF, 8'hFF);
    // The overflow reset is kept off while random traffic may run the stack deep.
    wr(pc_stack_pkg::ADDR_STACK_CONFIG, 8'h00);
    repeat (60)
    begin
      lf = lfsr(lf);
      op(pc_stack_pkg::flow_op_e'({1'b0, lf[1:0]} + 3'd1), {lf[15:2], lf[6:0]});
      if (lf[9:8] == 2'b00)
        rd(pc_stack_pkg::ADDR_STACK_POINTER, {full, unf, 1'b0, sp});
    end
    wr(pc_stack_pkg::ADDR_STACK_POINTER, 8'h00);
    {full, unf, sp} = '0;
    for (int i = 1; i <= 32; i++)
      op(pc_stack_pkg::FLOW_CALL, 21'(i * 8));
    rd(pc_stack_pkg::ADDR_STACK_POINTER, 8'h9F);
    rd(pc_stack_pkg::ADDR_STACK_TOP_LOW, stk[31][7:0]);
    wr(pc_stack_pkg::ADDR_STACK_POINTER, 8'h05);
    {full, unf, sp} = 7'h05;
    rd(pc_stack_pkg::ADDR_STACK_POINTER, 8'h05);
    op(pc_stack_pkg::FLOW_RETURN, 21'h0);
    wr(pc_stack_pkg::ADDR_STACK_CONFIG, 8'h01);
    wr(pc_stack_pkg::ADDR_STACK_POINTER, 8'h00);
    {full, unf, sp} = '0;
    for (int i = 1; i <= 31; i++)
      op(pc_stack_pkg::FLOW_CALL, 21'(i * 16));
    {pc, sp} = '0;
    see();
    chk(n_sres, 1);
    rd(pc_stack_pkg::ADDR_STACK_POINTER, 8'h80);
    op(pc_stack_pkg::FLOW_CALL, 21'h000100);
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    {pc, sp} = '0;
    rd(pc_stack_pkg::ADDR_STACK_POINTER, 8'h80);
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 6; k++)
      begin
        t = addrs[k];
        rt = route(m, k % 3, t);
        wr(pc_stack_pkg::ADDR_MEMORY_CONFIG, 8'(m));
        wr(pc_stack_pkg::ADDR_STACK_CONFIG, {5'h0, 2'(k % 3), 1'b0});
        i_table <= {1'b1, t};
        op(pc_stack_pkg::FLOW_JUMP, t);
        chk({o_fetch.use_external, o_fetch.zero_fill}, rt);
        chk(o_table_external, rt[1]);
        chk({o_fetch.blocked, o_table_blocked}, {2{rt[0]}});
        h0 = ext_hits;
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk(ext_hits - h0, rt[1] ? 16'h0003 : 16'h0000);
        if (rt[1])
          chk(ext_word, t[15:0] ^ 16'hA5A5);
      end
    tally_and_finish();
  end
endmodule
